// ---- design/ipvs_arbiter.sv ----
// file: priority pick among the eligible interrupt entries.
// assumes entry index equals vector field; lower index is lower vector.
`timescale 1ns/10ps
module ipvs_arbiter
  import ipvs_pkg::*;
(
  input  wire logic [ipvs_pkg::NUM_SRC-1:0]             eligible_in,
  input  wire logic [ipvs_pkg::NUM_SRC*ipvs_pkg::LVL_W-1:0] level_in,
  output logic                                          found_out,
  output logic [ipvs_pkg::IDX_W-1:0]                    index_out,
  output logic [ipvs_pkg::LVL_W-1:0]                    level_out
);
  import ipvs_pkg::*;

  // ****************************************
  // search
  // ****************************************
  always_comb begin
    found_out = 1'b0;
    index_out = '0;
    level_out = '0;
    // strict greater keeps the first (lowest) index on ties
    for (int i = 0; i < NUM_SRC; i++) begin
      if (eligible_in[i] && (!found_out || level_in[i*LVL_W +: LVL_W] > level_out)) begin
        found_out = 1'b1;
        index_out = IDX_W'(i);
        level_out = level_in[i*LVL_W +: LVL_W];
      end
    end
  end

endmodule // ipvs_arbiter

// ---- design/ipvs_pkg.sv ----
// package: register map, field layout, reset values and sizes of the
// interrupt priority and vector status block.
// assumes a 16-bit register port with a word index for the address.
package ipvs_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned NUM_TRAP   = 4;
  localparam int unsigned NUM_USER   = 4;
  localparam int unsigned NUM_SRC    = NUM_TRAP + NUM_USER;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned LVL_W      = 4;
  localparam int unsigned PRIO_W     = 3;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned STACK_D    = 16;
  localparam int unsigned SP_W       = 5;
  localparam int unsigned BLOCK_W    = 14;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [3:0] REG_INTERRUPT_CONTROL_ONE   = 4'h0;
  localparam logic [3:0] REG_FLAG_STATUS_REGS        = 4'h1;
  localparam logic [3:0] REG_ENABLE_CONTROL_REGS     = 4'h2;
  localparam logic [3:0] REG_PRIORITY_CONTROL_REGS   = 4'h3;
  localparam logic [3:0] REG_ADC_PAIR6_PRIORITY      = 4'h4;
  localparam logic [3:0] REG_LEVEL_VECTOR_STATUS     = 4'h5;
  localparam logic [3:0] REG_LOW_STATUS_BYTE         = 4'h6;
  localparam logic [3:0] REG_TIMED_INTERRUPT_BLOCK   = 4'h7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned NESTING_DISABLE_BIT = 15;
  localparam int unsigned TRAP_FLAG_LSB       = 1;
  localparam int unsigned STATUS_LEVEL_LSB    = 8;
  localparam int unsigned STATUS_VECTOR_LSB   = 0;
  localparam int unsigned STATUS_VECTOR_W     = 7;
  localparam int unsigned LOW_LEVEL_LSB       = 5;
  localparam int unsigned PRIO_FIELD_STRIDE   = 4;
  localparam int unsigned PAIR6_USER_IDX      = 3;

  // ****************************************
  // reset values and fixed levels
  // ****************************************
  localparam logic [2:0] PRIO_RESET      = 3'h4;
  localparam logic [2:0] PRIO_OFF        = 3'h0;
  localparam logic [2:0] PRIO_TOP_USER   = 3'h7;
  localparam logic [3:0] LEVEL_RESET     = 4'h0;
  localparam logic [3:0] LEVEL_USER_MAX  = 4'h7;
  // trap i sits at level 15 - i, all within 8..15
  localparam logic [3:0] TRAP_LEVEL_TOP  = 4'hF;
  localparam logic [15:0] DATA_ZERO      = 16'h0000;

endpackage : ipvs_pkg

// ---- design/ipvs_top.sv ----
// file: interrupt priority, nesting, masking and vector status logic.
// assumes a cpu core that takes the offered vector with a one-cycle
// take pulse and signals each return with a one-cycle return pulse.
//
// Behaviour
// - pair 6 done priority: 3 bits, 7 highest, 1 lowest, 0 disables.
// - every user priority field resets to level 4.
// - status bits 11:8 show current cpu level, read only.
// - status bits 6:0 show pending vector minus eight, read only.
// - nesting disable bit 15 stops user-source preemption of a routine in service; traps still preempt.
// - user request only with flag set, enable set, priority non-zero.
// - user flag holds until software clears; a held flag is retaken.
// - trap flags hold until cleared; a held trap is retaken.
// - return restores previous cpu level and low status byte at once.
// - cpu level 7 in the low status byte masks all user sources.
// - traps sit at levels 12 to 15 and are never masked.
// - timed block masks levels 1 to 6; level 7 still interrupts.
// - pair 6 priority register bits 15:3 read zero, writes ignored.
`timescale 1ns/10ps
module ipvs_top
  import ipvs_pkg::*;
(
  input  wire logic                           clk_sys_in,
  input  wire logic                           rst_n_in,
  input  wire logic [ipvs_pkg::ADDR_W-1:0]    reg_addr_in,
  input  wire logic [ipvs_pkg::DATA_W-1:0]    reg_wdata_in,
  input  wire logic                           reg_write_in,
  input  wire logic                           reg_read_in,
  output logic      [ipvs_pkg::DATA_W-1:0]    reg_rdata_out,
  input  wire logic [ipvs_pkg::NUM_USER-1:0]  user_event_in,
  input  wire logic [ipvs_pkg::NUM_TRAP-1:0]  trap_event_in,
  input  wire logic                           cpu_take_in,
  input  wire logic                           cpu_return_in,
  output logic                                irq_request_out,
  output logic      [ipvs_pkg::IDX_W-1:0]     irq_vector_index_out,
  output logic      [ipvs_pkg::LVL_W-1:0]     irq_level_out,
  output logic      [ipvs_pkg::LVL_W-1:0]     current_cpu_level_out
);
  import ipvs_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // state
  // ****************************************
  logic                      nesting_disable;
  logic [NUM_TRAP-1:0]       trap_flags;
  logic [NUM_USER-1:0]       user_flags;
  logic [NUM_USER-1:0]       user_enables;
  logic [PRIO_W-1:0]         user_prio [NUM_USER];
  logic [LVL_W-1:0]          current_cpu_level;
  logic [LVL_W-1:0]          level_stack [STACK_D];
  logic [SP_W-1:0]           stack_ptr;
  logic [BLOCK_W-1:0]        block_count;
  logic [DATA_W-1:0]         rdata;

  logic                      next_nesting_disable;
  logic [NUM_TRAP-1:0]       next_trap_flags;
  logic [NUM_USER-1:0]       next_user_flags;
  logic [NUM_USER-1:0]       next_user_enables;
  logic [PRIO_W-1:0]         next_user_prio [NUM_USER];
  logic [LVL_W-1:0]          next_current_cpu_level;
  logic [LVL_W-1:0]          next_level_stack [STACK_D];
  logic [SP_W-1:0]           next_stack_ptr;
  logic [BLOCK_W-1:0]        next_block_count;
  logic [DATA_W-1:0]         next_rdata;

  // ****************************************
  // eligibility
  // ****************************************
  logic [NUM_SRC-1:0]        eligible;
  logic [NUM_SRC*LVL_W-1:0]  src_level;
  logic                      win_found;
  logic [IDX_W-1:0]          win_index;
  logic [LVL_W-1:0]          win_level;
  logic                      in_service;
  logic                      block_active;
  logic                      take;

  assign in_service   = (stack_ptr != '0);
  assign block_active = (block_count != '0);

  genvar g;
  generate
    for (g = 0; g < NUM_TRAP; g++) begin : gen_trap
      localparam logic [LVL_W-1:0] TLVL = TRAP_LEVEL_TOP - LVL_W'(g);
      assign src_level[g*LVL_W +: LVL_W] = TLVL;
      // no mask, block or nesting term reaches a trap
      assign eligible[g] = trap_flags[g] && (TLVL > current_cpu_level);
    end
    for (g = 0; g < NUM_USER; g++) begin : gen_user
      localparam int unsigned S = NUM_TRAP + g;
      assign src_level[S*LVL_W +: LVL_W] = {1'b0, user_prio[g]};
      assign eligible[S] = user_flags[g] && user_enables[g]
                         && (user_prio[g] != PRIO_OFF)
                         && ({1'b0, user_prio[g]} > current_cpu_level)
                         && !(block_active && user_prio[g] != PRIO_TOP_USER)
                         && !(nesting_disable && in_service);
    end
  endgenerate

  ipvs_arbiter u_arbiter (
    .eligible_in (eligible),
    .level_in    (src_level),
    .found_out   (win_found),
    .index_out   (win_index),
    .level_out   (win_level)
  );

  assign take = cpu_take_in && win_found && (stack_ptr != SP_W'(STACK_D));

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_nesting_disable   = nesting_disable;
    next_trap_flags        = trap_flags;
    next_user_flags        = user_flags;
    next_user_enables      = user_enables;
    next_user_prio         = user_prio;
    next_current_cpu_level = current_cpu_level;
    next_level_stack       = level_stack;
    next_stack_ptr         = stack_ptr;

    if (reg_write_in) begin
      case (reg_addr_in)
        REG_INTERRUPT_CONTROL_ONE: begin
          next_nesting_disable = reg_wdata_in[NESTING_DISABLE_BIT];
          next_trap_flags      = reg_wdata_in[TRAP_FLAG_LSB +: NUM_TRAP];
        end
        REG_FLAG_STATUS_REGS: begin
          next_user_flags = reg_wdata_in[NUM_USER-1:0];
        end
        REG_ENABLE_CONTROL_REGS: begin
          next_user_enables = reg_wdata_in[NUM_USER-1:0];
        end
        REG_PRIORITY_CONTROL_REGS: begin
          for (int i = 0; i < NUM_USER; i++) begin
            if (i != PAIR6_USER_IDX) begin
              next_user_prio[i] = reg_wdata_in[i*PRIO_FIELD_STRIDE +: PRIO_W];
            end
          end
        end
        REG_ADC_PAIR6_PRIORITY: begin
          // upper bits have no storage at all
          next_user_prio[PAIR6_USER_IDX] = reg_wdata_in[PRIO_W-1:0];
        end
        REG_LOW_STATUS_BYTE: begin
          next_current_cpu_level = {1'b0, reg_wdata_in[LOW_LEVEL_LSB +: PRIO_W]};
        end
        default: begin
          // status, timed block and unmapped indices: not this group
        end
      endcase
    end

    // hardware set wins over a software clear in the same cycle
    next_user_flags = next_user_flags | user_event_in;
    next_trap_flags = next_trap_flags | trap_event_in;

    // a take and a return never share a cycle on a sane core; take wins
    if (take) begin
      next_level_stack[stack_ptr[SP_W-2:0]] = current_cpu_level;
      next_stack_ptr         = stack_ptr + SP_W'(1);
      next_current_cpu_level = win_level;
    end else if (cpu_return_in && in_service) begin
      // flags are left alone so a still-set flag is offered again
      next_stack_ptr         = stack_ptr - SP_W'(1);
      next_current_cpu_level = level_stack[next_stack_ptr[SP_W-2:0]];
    end
  end

  // ****************************************
  // timed block counter
  // ****************************************
  // a reload while counting restarts the whole window
  // traps and level 7 sources ignore the window, see eligibility
  always_comb begin
    next_block_count = block_active ? block_count - BLOCK_W'(1) : block_count;
    if (reg_write_in && reg_addr_in == REG_TIMED_INTERRUPT_BLOCK) begin
      next_block_count = reg_wdata_in[BLOCK_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      block_count <= '0;
    end else begin
      block_count <= next_block_count;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // registered so the port answers one cycle after the strobe
  always_comb begin
    next_rdata = DATA_ZERO;
    if (reg_read_in) begin
      case (reg_addr_in)
        REG_INTERRUPT_CONTROL_ONE: begin
          next_rdata[NESTING_DISABLE_BIT]         = nesting_disable;
          next_rdata[TRAP_FLAG_LSB +: NUM_TRAP]   = trap_flags;
        end
        REG_FLAG_STATUS_REGS: begin
          next_rdata[NUM_USER-1:0] = user_flags;
        end
        REG_ENABLE_CONTROL_REGS: begin
          next_rdata[NUM_USER-1:0] = user_enables;
        end
        REG_PRIORITY_CONTROL_REGS: begin
          for (int i = 0; i < NUM_USER; i++) begin
            if (i != PAIR6_USER_IDX) begin
              next_rdata[i*PRIO_FIELD_STRIDE +: PRIO_W] = user_prio[i];
            end
          end
        end
        REG_ADC_PAIR6_PRIORITY: begin
          next_rdata[PRIO_W-1:0] = user_prio[PAIR6_USER_IDX];
        end
        REG_LEVEL_VECTOR_STATUS: begin
          next_rdata[STATUS_LEVEL_LSB +: LVL_W] = current_cpu_level;
          next_rdata[STATUS_VECTOR_LSB +: STATUS_VECTOR_W] =
            STATUS_VECTOR_W'(win_index);
        end
        REG_LOW_STATUS_BYTE: begin
          // trap levels above 7 still show as 7 in the three bits
          next_rdata[LOW_LEVEL_LSB +: PRIO_W] = (current_cpu_level > LEVEL_USER_MAX) ?
            PRIO_TOP_USER : current_cpu_level[PRIO_W-1:0];
        end
        REG_TIMED_INTERRUPT_BLOCK: begin
          next_rdata[BLOCK_W-1:0] = block_count;
        end
        default: begin
          next_rdata = DATA_ZERO;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      nesting_disable   <= 1'b0;
      trap_flags        <= '0;
      user_flags        <= '0;
      user_enables      <= '0;
      for (int i = 0; i < NUM_USER; i++) begin
        user_prio[i] <= PRIO_RESET;
      end
      current_cpu_level <= LEVEL_RESET;
      for (int i = 0; i < STACK_D; i++) begin
        level_stack[i] <= LEVEL_RESET;
      end
      stack_ptr         <= '0;
    end else begin
      nesting_disable   <= next_nesting_disable;
      trap_flags        <= next_trap_flags;
      user_flags        <= next_user_flags;
      user_enables      <= next_user_enables;
      user_prio         <= next_user_prio;
      current_cpu_level <= next_current_cpu_level;
      level_stack       <= next_level_stack;
      stack_ptr         <= next_stack_ptr;
    end
  end

  // zero outside the answer cycle, so a stale word is never seen
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= DATA_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata_out         = rdata;
  assign irq_request_out       = win_found;
  assign irq_vector_index_out  = win_index;
  assign irq_level_out         = win_level;
  assign current_cpu_level_out = current_cpu_level;

endmodule // ipvs_top

// ---- tb/ipvs_checker.sv ----
// checker: port assertions for ipvs_top
// assumes one clock domain and the bind at the foot
`timescale 1ns/10ps
module ipvs_checker
  import ipvs_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [3:0]  user_event_in,
  input wire logic [3:0]  trap_event_in,
  input wire logic        cpu_take_in,
  input wire logic        cpu_return_in,
  input wire logic        irq_request_out,
  input wire logic [2:0]  irq_vector_index_out,
  input wire logic [3:0]  irq_level_out,
  input wire logic [3:0]  current_cpu_level_out
);
  // ********
  // helpers
  // ********
  logic rd_stat;
  logic rd_p6;
  logic lvl_cause;
  assign rd_stat = reg_read_in && reg_addr_in == REG_LEVEL_VECTOR_STATUS;
  assign rd_p6 = reg_read_in && reg_addr_in == REG_ADC_PAIR6_PRIORITY;
  // level may only move on take, return or a low status byte write
  assign lvl_cause = cpu_take_in || cpu_return_in ||
                     (reg_write_in && reg_addr_in == REG_LOW_STATUS_BYTE);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ********
  // assertions
  // ********
  stat_level_a: assert property (
    rd_stat |=> reg_rdata_out[15:8] == {4'h0, $past(current_cpu_level_out)})
    else $error("status level field wrong");
  stat_vector_a: assert property (
    rd_stat |=> reg_rdata_out[7:0] == {5'h00, $past(irq_vector_index_out)})
    else $error("status vector field wrong");
  p6_unused_a: assert property (rd_p6 |=> reg_rdata_out[15:3] == 13'h0)
    else $error("pair6 unused bits set");
  req_nonzero_a: assert property (irq_request_out |-> irq_level_out != 4'h0)
    else $error("request at level zero");
  req_above_a: assert property (
    irq_request_out |-> irq_level_out > current_cpu_level_out)
    else $error("request not above cpu level");
  take_level_a: assert property (
    cpu_take_in && irq_request_out |=> current_cpu_level_out == $past(irq_level_out))
    else $error("take did not load level");
  user_mask_a: assert property (
    current_cpu_level_out >= 4'h7 && irq_request_out |-> irq_vector_index_out < 3'h4)
    else $error("user source not masked");
  trap_live_a: assert property (
    trap_event_in[1] && !cpu_take_in && current_cpu_level_out < 4'hE
    |=> irq_request_out && irq_level_out >= 4'hE) else $error("trap was masked");
  level_cause_a: assert property (
    $changed(current_cpu_level_out) |-> $past(lvl_cause))
    else $error("level moved without cause");
endmodule // ipvs_checker

bind ipvs_top ipvs_checker u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out), .user_event_in(user_event_in),
  .trap_event_in(trap_event_in), .cpu_take_in(cpu_take_in),
  .cpu_return_in(cpu_return_in), .irq_request_out(irq_request_out),
  .irq_vector_index_out(irq_vector_index_out), .irq_level_out(irq_level_out),
  .current_cpu_level_out(current_cpu_level_out));

// ---- tb/ipvs_cpu_model.sv ----
// partner: cpu core taking offered vectors and returning on command
// assumes take_en_in, delay_in and ret_cmd_in change at the clock edge
`timescale 1ns/10ps
module ipvs_cpu_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       irq_request_in,
  input  wire logic       take_en_in,
  input  wire logic [1:0] delay_in,
  input  wire logic       ret_cmd_in,
  output logic            cpu_take_out,
  output logic            cpu_return_out
);
  // ********
  // take and return
  // ********
  logic [1:0] wait_cnt;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt <= 2'h0;
      cpu_take_out <= 1'b0;
      cpu_return_out <= 1'b0;
    end else begin
      cpu_return_out <= ret_cmd_in;
      cpu_take_out <= 1'b0;
      // slow core: needs delay_in + 1 cycles of steady request
      if (!take_en_in || !irq_request_in || cpu_take_out) begin
        wait_cnt <= 2'h0;
      end else if (wait_cnt == delay_in) begin
        cpu_take_out <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule // ipvs_cpu_model

// ---- tb/tb_top.sv ----
// testbench: scenarios for ipvs_top beside a cpu partner model
// assumes ipvs_top, ipvs_cpu_model and the bound checker
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  logic        clk_sys;
  logic        rst_n;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rdata;
  logic [3:0]  uev;
  logic [3:0]  tev;
  logic        take;
  logic        ret;
  logic        req;
  logic [2:0]  vidx;
  logic [3:0]  lvl;
  logic [3:0]  cur;
  logic        take_en;
  logic        ret_cmd;
  logic [1:0]  dly;
  int          miscompares = 0;
  int          num_checks = 0;
  ipvs_top DUT (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en),
    .reg_rdata_out(rdata), .user_event_in(uev), .trap_event_in(tev),
    .cpu_take_in(take), .cpu_return_in(ret), .irq_request_out(req),
    .irq_vector_index_out(vidx), .irq_level_out(lvl), .current_cpu_level_out(cur));
  ipvs_cpu_model u_cpu (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .irq_request_in(req),
    .take_en_in(take_en), .delay_in(dly), .ret_cmd_in(ret_cmd),
    .cpu_take_out(take), .cpu_return_out(ret));
  // ********
  // bus and cpu tasks
  // ********
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic chkrd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic pulse(input logic [3:0] u, input logic [3:0] t);
    @(posedge clk_sys);
    uev <= u;
    tev <= t;
    @(posedge clk_sys);
    uev <= 4'h0;
    tev <= 4'h0;
    #1;
  endtask
  task automatic cpu_ctl(input logic en, input logic [1:0] d, input logic r);
    @(posedge clk_sys);
    take_en <= en;
    dly <= d;
    ret_cmd <= r;
    @(posedge clk_sys);
    ret_cmd <= 1'b0;
    #1;
  endtask
  task automatic waitlvl(input logic [3:0] e);
    for (int i = 0; i < 20 && cur !== e; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(cur, e)
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_regs();
    chkrd(4'h4, 16'h0004);
    chkrd(4'h3, 16'h0444);
    wr(4'h5, 16'hFFFF);
    chkrd(4'h5, 16'h0000);
    wr(4'h4, 16'hFFFF);
    chkrd(4'h4, 16'h0007);
    chkrd(4'h9, 16'h0000);
  endtask
  task automatic t_prio();
    wr(4'h2, 16'h0008);
    pulse(4'h8, 4'h0);
    for (int i = 0; i < 8; i++) begin
      wr(4'h4, 16'(i));
      `CHK(req, (i != 0))
      if (i != 0) `CHK(lvl, 4'(i))
    end
    chkrd(4'h5, 16'h0007);
    wr(4'h2, 16'h0000);
    `CHK(req, 1'b0)
    wr(4'h2, 16'h0008);
    `CHK(req, 1'b1)
    wr(4'h1, 16'h0000);
    `CHK(req, 1'b0)
  endtask
  task automatic t_take();
    wr(4'h2, 16'h0003);
    pulse(4'h3, 4'h0);
    `CHK(vidx, 3'h4)
    chkrd(4'h1, 16'h0003);
    wr(4'h3, 16'h0454);
    `CHK(vidx, 3'h5)
    cpu_ctl(1'b1, 2'h2, 1'b0);
    waitlvl(4'h5);
    `CHK(req, 1'b0)
    wr(4'h0, 16'h8000);
    wr(4'h3, 16'h0457);
    `CHK(req, 1'b0)
    wr(4'h0, 16'h0000);
    waitlvl(4'h7);
    cpu_ctl(1'b0, 2'h0, 1'b1);
    waitlvl(4'h5);
    `CHK(vidx, 3'h4)
    cpu_ctl(1'b0, 2'h0, 1'b1);
    waitlvl(4'h0);
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0444);
  endtask
  task automatic t_mask();
    wr(4'h6, 16'h00E0);
    `CHK(cur, 4'h7)
    wr(4'h2, 16'h0008);
    wr(4'h4, 16'h0007);
    pulse(4'h8, 4'h0);
    `CHK(req, 1'b0)
    pulse(4'h0, 4'h2);
    `CHK(lvl, 4'hE)
    chkrd(4'h5, 16'h0701);
    cpu_ctl(1'b1, 2'h0, 1'b0);
    waitlvl(4'hE);
    chkrd(4'h6, 16'h00E0);
    chkrd(4'h0, 16'h0004);
    cpu_ctl(1'b0, 2'h0, 1'b1);
    waitlvl(4'h7);
    `CHK(req, 1'b1)
    wr(4'h0, 16'h0000);
    `CHK(req, 1'b0)
    wr(4'h6, 16'h0000);
    `CHK(lvl, 4'h7)
    wr(4'h7, 16'h0014);
    `CHK(req, 1'b1)
    chkrd(4'h7, 16'h0013);
    wr(4'h4, 16'h0006);
    `CHK(req, 1'b0)
    repeat (25) @(posedge clk_sys);
    #1;
    `CHK(lvl, 4'h6)
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ********
  // clock, watchdog, main
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // run needs under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    {addr, wdata, wr_en, rd_en, uev, tev} = '0;
    {take_en, ret_cmd, dly} = '0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_prio();
    t_take();
    t_mask();
    results();
  end
endmodule // tb_top
